// [pkg/tmr_consts.svh]
// register offsets, field positions, reset values and timing counts
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH
`define TMR_OFF_CONTROL 12'h000
`define TMR_OFF_LOW 12'h004
`define TMR_OFF_HIGH 12'h008
`define TMR_OFF_INTCTL 12'h00c
`define TMR_OFF_SYSCTL 12'h010
`define TMR_BIT_RUN 7
`define TMR_BIT_W8 6
`define TMR_BIT_CS 5
`define TMR_BIT_SE 4
`define TMR_BIT_PSA 3
`define TMR_BIT_IE 5
`define TMR_BIT_IF 2
`define TMR_BIT_SLEEP 0
`define TMR_BIT_POR 1
`define TMR_CONTROL_RST 8'hff
`define TMR_HIGH_RST 8'h00
`define TMR_WRITE_INHIBIT 2'h2
`endif

// [pkg/tmr_pkg.sv]
// types of the timer/counter block
package tmr_pkg;
  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } tmr_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tmr_apb_rsp_t;
  typedef enum logic {TMR_RUN, TMR_SLEEP} tmr_mode_t;
  typedef struct packed {
    logic [7:0] control;
    logic [7:0] count_low;
    logic [7:0] count_high;
    logic [7:0] count_high_buffer;
    logic [7:0] prescale;
    logic [1:0] inhibit;
    logic overflow_flag;
    logic overflow_irq_enable;
    logic [2:0] ext_sync;
    tmr_mode_t mode;
    logic [31:0] prdata;
    logic por_done;
  } tmr_state_t;
endpackage

// [logic/tmr_timer.sv]
// 8/16-bit timer/counter with prescaler and apb register slave
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "tmr_consts.svh"
// How it works
// RULE1: control bit 7 set lets the counter run, clear freezes it
// RULE2: control bit 6 one gives 8-bit counter, zero gives 16-bit
// RULE3: control bit 5 picks external pin edges or instruction cycles
// RULE4: control bit 4 one counts falling pin edges, zero rising
// RULE5: control bit 3 bypasses prescaler; clear routes source through prescaler
// RULE6: prescale field n divides by two to the power n plus one
// RULE7: control register resets to all ones
// RULE8: internal mode without prescaler counts every cycle
// RULE9: after a count write, increments are skipped for two cycles
// RULE10: external pin is synchronised before counting; source obeys timing limits
// RULE11: prescaler is an 8-bit counter software cannot access
// RULE12: count write clears prescaler, assignment bit kept; here only while bit 3 is clear
// RULE13: prescaler assignment may change at any time while running
// RULE14: overflow flag set on wrap FFh to 00h or FFFFh to 0000h
// RULE15: cleared enable masks the irq; software clears flag before re-enable
// RULE16: in sleep the timer stops, so no wake-up from overflow
// RULE17: low byte read copies high count byte into high buffer
// RULE18: low byte write loads high buffer into high count byte together
// RULE19: high buffer resets to zero; low byte kept on non power resets; here every presetn reset zeroes it
// RULE20: in 8-bit mode only the low byte counts and overflows
module tmr_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire tmr_pkg::tmr_apb_req_t apb_req,
  output tmr_pkg::tmr_apb_rsp_t apb_rsp,
  input wire logic ext_count_input,
  input wire logic sleep_request,
  output logic overflow_irq
);
  import tmr_pkg::*;

  tmr_state_t st;
  tmr_state_t next_st;

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  logic acc;
  logic wr;
  logic rd_setup;
  logic mapped;
  assign acc = apb_req.psel & apb_req.penable;
  assign wr = acc & apb_req.pwrite;
  // read setup cycle: data fetched here stands through the access phase
  assign rd_setup = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
  assign mapped = hit(apb_req.paddr, `TMR_OFF_CONTROL) | hit(apb_req.paddr, `TMR_OFF_LOW) |
                  hit(apb_req.paddr, `TMR_OFF_HIGH) | hit(apb_req.paddr, `TMR_OFF_INTCTL) |
                  hit(apb_req.paddr, `TMR_OFF_SYSCTL);
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = acc & ~mapped;
  assign apb_rsp.prdata = st.prdata;
  assign overflow_irq = st.overflow_flag & st.overflow_irq_enable;

  // ---------------------------------------------------------------
  // counting logic
  // ---------------------------------------------------------------
  logic pin_edge;
  logic src_tick;
  logic [7:0] ps_inc;
  logic ps_tick;
  logic inc;
  logic [15:0] cnt;
  logic [15:0] cnt_inc;
  logic wrap;

  always_comb begin
    next_st = st;
    // edge detect reads only the second and third sync stages
    pin_edge = st.control[`TMR_BIT_SE] ? (st.ext_sync[2] & ~st.ext_sync[1])
                                       : (~st.ext_sync[2] & st.ext_sync[1]);
    // RULE3 source select
    src_tick = st.control[`TMR_BIT_CS] ? pin_edge : 1'b1;
    ps_inc = st.prescale + 8'h01;
    // RULE6 divide ratio
    ps_tick = src_tick & (ps_inc[st.control[2:0]] & ~st.prescale[st.control[2:0]]);
    // RULE1 run gate
    inc = st.control[`TMR_BIT_RUN] && (st.mode == TMR_RUN) && (st.inhibit == 2'h0) &&
          // RULE5 prescaler bypass
          (st.control[`TMR_BIT_PSA] ? src_tick : ps_tick);
    cnt = {st.count_high, st.count_low};
    cnt_inc = cnt + 16'h0001;
    // RULE14 overflow detection
    // RULE20 only low byte in 8-bit mode
    wrap = inc && (st.control[`TMR_BIT_W8] ? (st.count_low == 8'hff) : (cnt == 16'hffff));

    // RULE10 two-stage sync then edge stage
    next_st.ext_sync = {st.ext_sync[1:0], ext_count_input};
    // RULE11 internal prescaler count
    // RULE13 assignment may switch any time
    if (src_tick && st.control[`TMR_BIT_RUN] && st.mode == TMR_RUN) begin
      next_st.prescale = ps_inc;
    end
    if (st.inhibit != 2'h0) begin
      next_st.inhibit = st.inhibit - 2'h1;
    end
    // RULE8 increment each enabled cycle
    if (inc) begin
      if (st.control[`TMR_BIT_W8]) begin
        next_st.count_low = st.count_low + 8'h01;
      end else begin
        next_st.count_low = cnt_inc[7:0];
        next_st.count_high = cnt_inc[15:8];
      end
    end
    // RULE16 sleep stops the timer
    next_st.mode = sleep_request ? TMR_SLEEP : TMR_RUN;
    next_st.por_done = 1'b1;

    if (wr) begin
      if (hit(apb_req.paddr, `TMR_OFF_CONTROL)) begin
        next_st.control = apb_req.pwdata[7:0];
      end
      if (hit(apb_req.paddr, `TMR_OFF_HIGH)) begin
        next_st.count_high_buffer = apb_req.pwdata[7:0];
      end
      if (hit(apb_req.paddr, `TMR_OFF_LOW)) begin
        next_st.count_low = apb_req.pwdata[7:0];
        // RULE18 atomic 16-bit load
        if (!st.control[`TMR_BIT_W8]) begin
          next_st.count_high = st.count_high_buffer;
        end
        // RULE9 two-cycle inhibit
        next_st.inhibit = `TMR_WRITE_INHIBIT;
        // RULE12 prescaler cleared only while bit 3 is clear, assignment kept
        if (!st.control[`TMR_BIT_PSA]) begin
          next_st.prescale = 8'h00;
        end
      end
      if (hit(apb_req.paddr, `TMR_OFF_INTCTL)) begin
        // RULE15 enable gates the irq
        next_st.overflow_irq_enable = apb_req.pwdata[`TMR_BIT_IE];
        next_st.overflow_flag = apb_req.pwdata[`TMR_BIT_IF];
      end
    end
    // set wins over clear
    if (wrap) begin
      next_st.overflow_flag = 1'b1;
    end

    // low byte and high copy taken at one edge, so the 16-bit pair is coherent
    next_st.prdata = 32'h0000_0000;
    if (rd_setup) begin
      if (hit(apb_req.paddr, `TMR_OFF_CONTROL)) begin
        next_st.prdata[7:0] = st.control;
      end
      if (hit(apb_req.paddr, `TMR_OFF_LOW)) begin
        next_st.prdata[7:0] = st.count_low;
        // RULE17 latch high byte on low read
        if (!st.control[`TMR_BIT_W8]) begin
          next_st.count_high_buffer = st.count_high;
        end
      end
      if (hit(apb_req.paddr, `TMR_OFF_HIGH)) begin
        next_st.prdata[7:0] = st.count_high_buffer;
      end
      if (hit(apb_req.paddr, `TMR_OFF_INTCTL)) begin
        next_st.prdata[`TMR_BIT_IE] = st.overflow_irq_enable;
        next_st.prdata[`TMR_BIT_IF] = st.overflow_flag;
      end
      if (hit(apb_req.paddr, `TMR_OFF_SYSCTL)) begin
        next_st.prdata[`TMR_BIT_SLEEP] = (st.mode == TMR_SLEEP);
        next_st.prdata[`TMR_BIT_POR] = st.por_done;
      end
    end
  end

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  // RULE7 control resets to all ones
  // RULE19 high buffer resets to zero, low byte zeroed by every presetn reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.control <= `TMR_CONTROL_RST;
      st.count_low <= 8'h00;
      st.count_high <= 8'h00;
      st.count_high_buffer <= `TMR_HIGH_RST;
      st.prescale <= 8'h00;
      st.inhibit <= 2'h0;
      st.overflow_flag <= 1'b0;
      st.overflow_irq_enable <= 1'b0;
      st.ext_sync <= 3'h0;
      st.mode <= TMR_RUN;
      st.prdata <= 32'h0000_0000;
      st.por_done <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// [tb/tmr_pulse_src.sv]
// external count pin source
`timescale 1ns/1ps
module tmr_pulse_src (
  input wire logic clk,
  output logic pin
);
  initial pin = 1'b0;
  task automatic toggle(input int n);
    repeat (n) begin
      repeat (6) @(posedge clk);
      pin <= ~pin;
    end
  endtask
endmodule

// [tb/tmr_timer_properties.sv]
// port assertions of the timer
`timescale 1ns/1ps
module tmr_timer_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire tmr_pkg::tmr_apb_req_t apb_req,
  input wire tmr_pkg::tmr_apb_rsp_t apb_rsp,
  input wire logic ext_count_input,
  input wire logic sleep_request,
  input wire logic overflow_irq
);
  import tmr_pkg::*;
  logic acc, wr, rd;
  logic [11:0] pa;
  logic [7:0] ctl;
  logic ien;
  assign acc = apb_req.psel && apb_req.penable;
  assign wr = acc && apb_req.pwrite;
  assign rd = acc && !apb_req.pwrite;
  assign pa = apb_req.paddr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= 8'hff;
      ien <= 1'b0;
    end else begin
      if (wr && pa == 12'h000) ctl <= apb_req.pwdata[7:0];
      if (wr && pa == 12'h00c) ien <= apb_req.pwdata[5];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ctrl_readback: assert property (rd && pa == 12'h000 |-> apb_rsp.prdata[7:0] == ctl)
    else $error("control readback wrong");
  a_irq_masked: assert property (overflow_irq |-> ien)
    else $error("irq while masked");
  a_irq_after_reset: assert property ($rose(presetn) |-> !overflow_irq)
    else $error("irq after reset");
  a_sleep_no_irq: assert property ($past(sleep_request, 2) && $past(sleep_request)
    && sleep_request && !$past(wr) |-> !$rose(overflow_irq)) else $error("irq in sleep");
  a_stop_no_irq: assert property ((!ctl[7] && !wr) [*3] |-> !$rose(overflow_irq))
    else $error("irq while stopped");
  a_err_unmapped: assert property (acc && pa > 12'h010 |-> apb_rsp.pslverr)
    else $error("no error on unmapped");
  a_err_mapped: assert property (acc && pa <= 12'h010 && pa[1:0] == 2'h0 |-> !apb_rsp.pslverr)
    else $error("error on mapped");
  a_unmapped_zero: assert property (rd && pa > 12'h010 |-> apb_rsp.prdata == 32'h0)
    else $error("unmapped read not zero");
  c_low_write: cover property (wr && pa == 12'h004);
  c_irq: cover property ($rose(overflow_irq));
  c_err: cover property (acc && apb_rsp.pslverr);
endmodule

// [tb/tmr_timer_test.sv]
// self-checking bench of the timer
`timescale 1ns/1ps
module tmr_timer_test;
  import tmr_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic sleep_request = 1'b0;
  logic overflow_irq, pin;
  tmr_apb_req_t req = '0;
  tmr_apb_rsp_t rsp;
  logic [31:0] rd;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  int t0;
  logic [27:0] rows [5] = '{{12'h000, 8'h5a, 8'h5a}, {12'h008, 8'ha5, 8'ha5},
    {12'h00c, 8'h20, 8'h20}, {12'h014, 8'h77, 8'h00}, {12'h010, 8'hff, 8'h02}};
  always #10 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  tmr_timer u_tmr_timer (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .ext_count_input(pin), .sleep_request(sleep_request), .overflow_irq(overflow_irq));
  tmr_pulse_src u_tmr_pulse_src (.clk(pclk), .pin(pin));
  task automatic final_report();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    int i;
    req.paddr <= a;
    req.pwrite <= w;
    req.pwdata <= {24'h0, d};
    req.psel <= 1'b1;
    @(posedge pclk);
    req.penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (rsp.pready !== 1'b1 && i < 50);
    // read data taken at the edge that sees pready high
    rd = rsp.prdata;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (rsp.pready !== 1'b1) begin
      n_mismatch++;
      final_report();
    end
    @(posedge pclk);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
    apb(a, 1'b0, 8'h00);
    cmp(rd[7:0] & m, e);
  endtask
  task automatic rst(input int n);
    presetn <= 1'b0;
    repeat (n) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(12'h000, 8'hff, 8'hff);
    rchk(12'h008, 8'hff, 8'h00);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    rst(8);
    foreach (rows[k]) begin
      apb(rows[k][27:16], 1'b1, rows[k][15:8]);
      rchk(rows[k][27:16], 8'hff, rows[k][7:0]);
    end
    apb(12'h000, 1'b1, 8'hc8);
    apb(12'h004, 1'b1, 8'hf0);
    t0 = cyc;
    repeat (4) @(posedge pclk);
    apb(12'h004, 1'b0, 8'h00);
    cmp(rd[7:0], 8'(8'hf0 + cyc - t0 - 4));
    apb(12'h00c, 1'b1, 8'h00);
    apb(12'h004, 1'b1, 8'hfe);
    repeat (6) @(posedge pclk);
    cmp({7'h0, overflow_irq}, 8'h00);
    rchk(12'h00c, 8'h24, 8'h04);
    apb(12'h00c, 1'b1, 8'h24);
    cmp({7'h0, overflow_irq}, 8'h01);
    apb(12'h00c, 1'b1, 8'h20);
    cmp({7'h0, overflow_irq}, 8'h00);
    apb(12'h000, 1'b1, 8'h88);
    apb(12'h008, 1'b1, 8'h12);
    apb(12'h004, 1'b1, 8'h34);
    rchk(12'h004, 8'hff, 8'h34);
    rchk(12'h008, 8'hff, 8'h12);
    for (int h = 0; h < 2; h++) begin
      apb(12'h00c, 1'b1, 8'h00);
      apb(12'h008, 1'b1, h ? 8'hff : 8'hfe);
      apb(12'h004, 1'b1, 8'hf8);
      repeat (12) @(posedge pclk);
      rchk(12'h00c, 8'h04, h ? 8'h04 : 8'h00);
    end
    for (int p = 0; p < 8; p++) begin
      apb(12'h000, 1'b1, 8'(8'hc0 | p));
      apb(12'h004, 1'b1, 8'h00);
      t0 = cyc;
      repeat (3 << (p + 1)) @(posedge pclk);
      apb(12'h004, 1'b0, 8'h00);
      t0 = (cyc - t0) / (2 << p) - int'(rd[7:0]);
      cmp({7'h0, t0 inside {[-1:1]}}, 8'h01);
    end
    for (int s = 0; s < 2; s++) begin
      sleep_request <= s[0];
      apb(12'h000, 1'b1, s ? 8'hc8 : 8'h48);
      apb(12'h004, 1'b1, 8'h20);
      repeat (6) @(posedge pclk);
      rchk(12'h004, 8'hff, 8'h20);
    end
    sleep_request <= 1'b0;
    for (int e = 0; e < 2; e++) begin
      apb(12'h000, 1'b1, e ? 8'hf8 : 8'he8);
      apb(12'h004, 1'b1, 8'h00);
      u_tmr_pulse_src.toggle(e ? 3 : 5);
      repeat (8) @(posedge pclk);
      rchk(12'h004, 8'hff, e ? 8'h02 : 8'h03);
    end
    rst(2);
    final_report();
  end
endmodule
bind tmr_timer tmr_timer_properties u_tmr_timer_properties (.pclk(pclk), .presetn(presetn),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .ext_count_input(ext_count_input),
  .sleep_request(sleep_request), .overflow_irq(overflow_irq));
